// *** hw/supply_fault_irq_enable_bank.sv ***
// supply fault interrupt enable bank with sticky status, clear and interrupt output
//
// Local design decisions: strobed register access and the register offsets.
`include "supply_fault_defs.svh"

// Function
// R1: read gives 2h enabled, 0h disabled
// R2: write 1h disables, 3h enables interrupt
// R3: bits 7-6 input over-current, reset enabled
// R4: bits 5-4 logic under-voltage, reset enabled
// R5: bits 3-2 input over-voltage, reset enabled
// R6: register at 08h, reset 2AAAh, top reserved
// R7: writing 0h or 2h keeps the state
module supply_fault_irq_enable_bank #(
  parameter int NUM_FIELDS = `SF_NUM_FIELDS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [`SF_ADDR_W-1:0] bus_addr,
  input  wire logic [`SF_DATA_W-1:0] bus_wdata,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  output logic      [`SF_DATA_W-1:0] bus_rdata,
  input  wire logic [NUM_FIELDS-1:0] fault_raw,
  output logic [NUM_FIELDS-1:0]      irq_enable_state,
  output logic                       irq
);

  // overview: seven two-bit enable fields behind a plain register port,
  // sticky fault status with a clear register, and one level interrupt;
  // registers: 08h enable, 0Ch status, 10h clear, 14h filtered fault level

  // ---- register port request carried as one struct
  // the bus never waits: writes land on the strobe edge, reads answer a cycle later
  supply_fault_pkg::bus_req_s req;      // bundled request of this cycle

  // bundle the port signals; one process drives every member of the struct
  always_comb
  begin
    req.addr  = bus_addr;               // byte address, meaningful with a strobe
    req.wdata = bus_wdata;              // write data, used with the write strobe
    req.wr    = bus_wr;                 // one-cycle write strobe
    req.rd    = bus_rd;                 // one-cycle read strobe
  end

  // ---- address decode
  logic hit_enable;                     // enable register selected
  logic hit_status;                     // sticky status register selected
  logic hit_clear;                      // write-only clear register selected
  logic hit_level;                      // live fault level register selected
  logic wr_enable;                      // write strobe aimed at the enable register
  logic wr_clear;                       // write strobe aimed at the clear register

  // full byte-address match; partial decode would alias the unmapped holes
  function automatic logic addr_hit(input logic [`SF_ADDR_W-1:0] addr,
                                    input logic [`SF_ADDR_W-1:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // compare the address against each mapped register
  always_comb
  begin
    hit_enable = addr_hit(req.addr, `SF_ADDR_ENABLE); // R6
    hit_status = addr_hit(req.addr, `SF_ADDR_STATUS);
    hit_clear  = addr_hit(req.addr, `SF_ADDR_CLEAR);
    hit_level  = addr_hit(req.addr, `SF_ADDR_LEVEL);
    // qualified writes; the enable one feeds every field and the reserved pair
    wr_enable  = req.wr && hit_enable;
    wr_clear   = req.wr && hit_clear;
  end

  // ---- reserved top bits of the enable register
  // software may write them; nothing inside the block acts on them
  logic [`SF_RSVD_MSB:`SF_RSVD_LSB] rsvd_ff;  // plain storage, no effect on logic

  // whole-register reset value; the reserved pair takes its own slice of it
  localparam logic [`SF_DATA_W-1:0] ENABLE_RESET = `SF_ENABLE_RESET;

  // reserved pair is read/write and resets to zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsvd_ff <= ENABLE_RESET[`SF_RSVD_MSB:`SF_RSVD_LSB]; // R6
    end
    else if (wr_enable)
    begin
      rsvd_ff <= req.wdata[`SF_RSVD_MSB:`SF_RSVD_LSB]; // R6
    end
  end

  // ---- the seven enable fields
  logic [NUM_FIELDS-1:0] field_en;     // enabled state of every field

  // field map, field i at bits 2i+1:2i of the enable register:
  //   0 input under-voltage
  //   1 input over-voltage
  //   2 logic-supply under-voltage
  //   3 input over-current
  //   4 pump capacitor missing
  //   5 charge pump
  //   6 boost sync lost
  // one field instance per supply fault; every field resets to enabled
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FIELDS; gi++)
    begin : g_field
      // field gi decodes its own slice of the write data
      irq_enable_field #(
        .RESET_ENABLED (1'b1)             // R3 R4 R5
      ) u_field (
        .clk           (clk),
        .rst_n         (rst_n),
        .wr_hit        (wr_enable),
        .wr_code       (supply_fault_pkg::field_slice(req.wdata, gi)), // R3 R4 R5
        .enabled_ff    (field_en[gi])
      );
    end
  endgenerate

  // the enable states leave the block straight from the field flip-flops;
  // bit i of this port mirrors field i of the enable register
  assign irq_enable_state = field_en;

  // ---- fault input synchronisers
  // the level register shows the filtered levels, not the raw pins
  logic [NUM_FIELDS-1:0] sync1_ff;     // first stage, read only by the second
  logic [NUM_FIELDS-1:0] sync2_ff;     // second stage
  logic [NUM_FIELDS-1:0] sync3_ff;     // third stage
  logic [NUM_FIELDS-1:0] level_ff;     // accepted fault level

  // three-stage capture of the asynchronous fault levels; only the second
  // stage reads the first, so a metastable first stage never reaches logic
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end
    else
    begin
      sync1_ff <= fault_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // a level change counts only once the second and third stages agree;
  // a level held for two sampling edges is always taken, a shorter glitch never
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      level_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_FIELDS; i++)
      begin
        if (sync2_ff[i] == sync3_ff[i])
        begin
          level_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  // ---- event detection
  logic [NUM_FIELDS-1:0] nxt_level;    // level the filter takes this cycle
  logic [NUM_FIELDS-1:0] fault_event;  // one-cycle pulse on a new fault

  // next accepted level, used to spot a rising fault
  // only a rise makes an event; a fault that stays high is caught once
  always_comb
  begin
    for (int i = 0; i < NUM_FIELDS; i++)
    begin
      nxt_level[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : level_ff[i];
    end
    fault_event = nxt_level & ~level_ff;
  end

  // ---- sticky status with write-one-to-clear
  // one status bit per field, in the same order as the fields
  logic [NUM_FIELDS-1:0] status_ff;    // sticky fault events
  logic [NUM_FIELDS-1:0] nxt_status;   // status after this cycle
  logic [NUM_FIELDS-1:0] clear_mask;   // bits software clears this cycle

  // clear bits come from a write to the clear register only
  // a written one clears a bit; upper data bits have no clear target
  always_comb
  begin
    if (wr_clear)
    begin
      clear_mask = req.wdata[NUM_FIELDS-1:0];
    end
    else
    begin
      clear_mask = '0;
    end
    // an event in the clear cycle wins over the clear
    nxt_status = (status_ff & ~clear_mask) | fault_event;
  end

  // status register update; every event is caught whatever its enable
  // so software can poll faults whose interrupt it keeps masked
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      status_ff <= '0;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  // ---- interrupt output
  logic nxt_irq;                       // next interrupt level

  // interrupt follows enabled status bits; enable state gates it
  // the level uses the status of the coming cycle, so irq rises on the
  // same edge as its status bit; an enable change shows one edge later
  always_comb
  begin
    nxt_irq = |(nxt_status & field_en);
  end

  // registered interrupt level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= nxt_irq;
    end
  end

  // ---- read path
  logic [`SF_DATA_W-1:0] enable_word;  // enable register as software reads it
  logic [`SF_DATA_W-1:0] nxt_rdata;    // read data for the next cycle

  // assemble the enable register from the field states
  // every field reads 2h when enabled and 0h when disabled; reserved pair as stored
  always_comb
  begin
    enable_word = '0;
    for (int i = 0; i < NUM_FIELDS; i++)
    begin
      enable_word[i*`SF_FIELD_W +: `SF_FIELD_W] =
        supply_fault_pkg::field_read_code(field_en[i]); // R1
    end
    enable_word[`SF_RSVD_MSB:`SF_RSVD_LSB] = rsvd_ff;
  end

  // select the addressed register; unmapped and write-only read as zero
  // the strobe gates the mux so the data port rests at zero between reads
  always_comb
  begin
    nxt_rdata = '0;
    if (req.rd)
    begin
      if (hit_enable)
      begin
        nxt_rdata = enable_word;                     // R1
      end
      else if (hit_status)
      begin
        nxt_rdata[NUM_FIELDS-1:0] = status_ff;
      end
      else if (hit_level)
      begin
        nxt_rdata[NUM_FIELDS-1:0] = level_ff;
      end
      else
      begin
        nxt_rdata = '0;
      end
    end
  end

  // read data stand in the cycle after the read strobe only
  // reads have no side effect; status bits clear only through the clear register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bus_rdata <= '0;
    end
    else
    begin
      bus_rdata <= nxt_rdata;
    end
  end

endmodule : supply_fault_irq_enable_bank

// *** hw/supply_fault_defs.svh ***
// register offsets, field positions, reset values and codes of the supply fault enable bank
`ifndef SUPPLY_FAULT_DEFS_SVH
`define SUPPLY_FAULT_DEFS_SVH

// register byte addresses on the plain register port
`define SF_ADDR_ENABLE       8'h08
`define SF_ADDR_STATUS       8'h0C
`define SF_ADDR_CLEAR        8'h10
`define SF_ADDR_LEVEL        8'h14

// widths
`define SF_ADDR_W            8
`define SF_DATA_W            16
`define SF_NUM_FIELDS        7
`define SF_FIELD_W           2

// field index of each supply fault (field i sits at bits 2i+1:2i)
`define SF_IDX_IN_UV         0
`define SF_IDX_IN_OV         1
`define SF_IDX_LOGIC_UV      2
`define SF_IDX_IN_OC         3
`define SF_IDX_PUMP_CAP      4
`define SF_IDX_PUMP          5
`define SF_IDX_SYNC_LOST     6

// reserved top bits of the enable register
`define SF_RSVD_LSB          14
`define SF_RSVD_MSB          15

// reset value of the whole enable register
`define SF_ENABLE_RESET      16'h2AAA

// field codes
`define SF_CODE_KEEP_LO      2'h0
`define SF_CODE_DISABLE      2'h1
`define SF_CODE_KEEP_HI      2'h2
`define SF_CODE_ENABLE       2'h3
`define SF_READ_ENABLED      2'h2
`define SF_READ_DISABLED     2'h0

`endif

// *** hw/supply_fault_pkg.sv ***
// types and field helpers of the supply fault enable bank
`include "supply_fault_defs.svh"

package supply_fault_pkg;

  // write codes of one two-bit enable field
  typedef enum logic [1:0] {
    code_keep_lo = `SF_CODE_KEEP_LO,
    code_disable = `SF_CODE_DISABLE,
    code_keep_hi = `SF_CODE_KEEP_HI,
    code_enable  = `SF_CODE_ENABLE
  } field_code_e;

  // one register port request
  typedef struct packed {
    logic [`SF_ADDR_W-1:0] addr;
    logic [`SF_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } bus_req_s;

  // read value of a field from its enabled state
  function automatic logic [`SF_FIELD_W-1:0] field_read_code(input logic enabled);
    field_read_code = enabled ? `SF_READ_ENABLED : `SF_READ_DISABLED;
  endfunction : field_read_code

  // slice one field's write code out of a data word
  function automatic field_code_e field_slice(input logic [`SF_DATA_W-1:0] word,
                                              input int unsigned            idx);
    field_slice = field_code_e'(word[idx*`SF_FIELD_W +: `SF_FIELD_W]);
  endfunction : field_slice

endpackage : supply_fault_pkg

// *** hw/irq_enable_field.sv ***
// one two-bit interrupt enable field with its write-code decode
`include "supply_fault_defs.svh"

module irq_enable_field #(
  parameter bit RESET_ENABLED = 1'b1
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      wr_hit,
  input  wire supply_fault_pkg::field_code_e wr_code,
  output logic                           enabled_ff
);

  // held state; only codes 1h and 3h move it, 0h and 2h leave it alone
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      enabled_ff <= RESET_ENABLED;
    end
    else if (wr_hit)
    begin
      unique case (wr_code)
        supply_fault_pkg::code_disable : enabled_ff <= 1'b0;       // R2
        supply_fault_pkg::code_enable  : enabled_ff <= 1'b1;       // R2
        supply_fault_pkg::code_keep_lo : enabled_ff <= enabled_ff; // R7
        supply_fault_pkg::code_keep_hi : enabled_ff <= enabled_ff; // R7
      endcase
    end
  end

endmodule : irq_enable_field

// *** verif/sf_bank_chk.sv ***
// assertions on the ports of the supply fault enable bank
`include "supply_fault_defs.svh"
module sf_bank_chk #(
  parameter int NUM_FIELDS = 7
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [7:0]            bus_addr,
  input wire logic [15:0]           bus_wdata,
  input wire logic                  bus_wr,
  input wire logic                  bus_rd,
  input wire logic [15:0]           bus_rdata,
  input wire logic [NUM_FIELDS-1:0] fault_raw,
  input wire logic [NUM_FIELDS-1:0] irq_enable_state,
  input wire logic                  irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // strobes aimed at the enable register
  wire rd_en = bus_rd && bus_addr == `SF_ADDR_ENABLE;
  wire wr_en = bus_wr && bus_addr == `SF_ADDR_ENABLE;
  a_read_low_zero: assert property (rd_en |=> (bus_rdata & 16'h1555) == 16'h0000)
    else $error("enable read low bit set");
  a_code_disable: assert property (wr_en && bus_wdata[7:6] == 2'h1 |=> !irq_enable_state[3])
    else $error("disable code ignored");
  a_code_enable: assert property (wr_en && bus_wdata[3:2] == 2'h3 |=> irq_enable_state[1])
    else $error("enable code ignored");
  a_oc_read: assert property (rd_en |=> bus_rdata[7:6] == {$past(irq_enable_state[3]), 1'b0})
    else $error("over-current field read wrong");
  a_uv_read: assert property (rd_en |=> bus_rdata[5:4] == {$past(irq_enable_state[2]), 1'b0})
    else $error("under-voltage field read wrong");
  a_ov_read: assert property (rd_en |=> bus_rdata[3:2] == {$past(irq_enable_state[1]), 1'b0})
    else $error("over-voltage field read wrong");
  a_reset_state: assert property ($rose(rst_n) |-> irq_enable_state == '1)
    else $error("fields not enabled after reset");
  a_keep_code: assert property (wr_en && !bus_wdata[4] |=> $stable(irq_enable_state[2]))
    else $error("keep code changed field");
  // main scenarios reached
  c_read: cover property (rd_en);
  c_irq: cover property (irq);
  c_off: cover property (wr_en && bus_wdata[7:6] == 2'h1);
endmodule : sf_bank_chk

bind supply_fault_irq_enable_bank sf_bank_chk #(.NUM_FIELDS(NUM_FIELDS)) chk_u (
  .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .fault_raw(fault_raw),
  .irq_enable_state(irq_enable_state), .irq(irq));

// *** verif/tb.sv ***
// self-checking bench of the supply fault enable bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] en_a = 8'h08; // enable register
  localparam logic [7:0] st_a = 8'h0C; // sticky status
  localparam logic [7:0] cl_a = 8'h10; // status clear
  localparam logic [7:0] lv_a = 8'h14; // filtered fault level
  logic        clk;
  logic        rst_n;
  logic [7:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_rdata;
  logic [6:0]  fault_raw;
  logic [6:0]  irq_enable_state;
  logic        irq;
  int          fails;
  int          tests_run;
  supply_fault_irq_enable_bank dut_u (
    .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .fault_raw(fault_raw),
    .irq_enable_state(irq_enable_state), .irq(irq));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic close_out;
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr
  // read data sampled in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk(what, exp, bus_rdata);
  endtask : rd
  // bounded wait for the interrupt level
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("irq", {15'h0, v}, {15'h0, irq});
    if (irq !== v)
      close_out();
  endtask : wait_irq
  task automatic t_reset;
    rd(en_a, 16'h2AAA, "enable reset");
    chk("state", 16'h007F, {9'h0, irq_enable_state});
  endtask : t_reset
  task automatic t_codes;
    wr(en_a, 16'h0054);
    rd(en_a, 16'h2A02, "disable");
    chk("state off", 16'h0071, {9'h0, irq_enable_state});
    wr(en_a, 16'h00A0);
    rd(en_a, 16'h2A02, "keep");
    wr(en_a, 16'h00FC);
    rd(en_a, 16'h2AAA, "enable");
  endtask : t_codes
  task automatic t_misc;
    wr(en_a, 16'hC000);
    rd(en_a, 16'hEAAA, "reserved");
    wr(8'h04, 16'h5555);
    rd(8'h04, 16'h0000, "unmapped");
    rd(en_a, 16'hEAAA, "after unmapped");
    wr(en_a, 16'h0000);
  endtask : t_misc
  // over-current event: raise, mask, unmask, clear
  task automatic t_irq;
    @(posedge clk);
    fault_raw <= 7'h08;
    wait_irq(1'b1);
    rd(st_a, 16'h0008, "status");
    rd(lv_a, 16'h0008, "level high");
    wr(en_a, 16'h0040);
    wait_irq(1'b0);
    wr(en_a, 16'h00C0);
    wait_irq(1'b1);
    @(posedge clk);
    fault_raw <= 7'h00;
    wr(cl_a, 16'h0008);
    wait_irq(1'b0);
    rd(st_a, 16'h0000, "cleared");
    rd(lv_a, 16'h0000, "level low");
  endtask : t_irq
  // reset in mid-run brings every field and the reserved pair back
  task automatic t_again;
    wr(en_a, 16'hC054);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(en_a, 16'h2AAA, "enable after reset");
    chk("state after reset", 16'h007F, {9'h0, irq_enable_state});
  endtask : t_again
  initial
  begin
    rst_n = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    fault_raw = 7'h00;
    fails = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_codes();
    t_misc();
    t_irq();
    t_again();
    close_out();
  end
endmodule : tb
